//--- rtl/jlsp_packer.sv
// lane sample packer: maps one frame of converter samples onto two lane groups
`timescale 1ns/10ps
`include "jlsp_params.svh"

module jlsp_packer (
    input wire logic core_clk, // frame clock, 40 MHz
    input wire logic rst_b, // synchronous reset, active low
    input wire jlsp_pkg::jlsp_mode_t lanePackingMode, // selected lane packing mode
    input wire logic sampleValid, // one frame of samples is presented
    input wire jlsp_pkg::jlsp_dec_vec_t chanOneInphase, // channel one (or single) I samples
    input wire jlsp_pkg::jlsp_dec_vec_t chanOneQuadrature, // channel one (or single) Q samples
    input wire jlsp_pkg::jlsp_dec_vec_t chanTwoInphase, // channel two I samples
    input wire jlsp_pkg::jlsp_dec_vec_t chanTwoQuadrature, // channel two Q samples
    input wire logic [3:0] chanOneIOverflow, // channel one I overflow flags
    input wire logic [3:0] chanOneQOverflow, // channel one Q overflow flags
    input wire logic [3:0] chanTwoIOverflow, // channel two I overflow flags
    input wire logic [3:0] chanTwoQOverflow, // channel two Q overflow flags
    input wire logic [3:0] inphaseOverflow, // single-channel I overflow flags
    input wire logic [3:0] quadratureOverflow, // single-channel Q overflow flags
    input wire jlsp_pkg::jlsp_byp_vec_t bypassSample, // bypass samples, dual uses 0-7 and 8-15
    output jlsp_pkg::jlsp_group_t firstLaneGroup, // group one lane frames, octet 0 in [31:24]
    output jlsp_pkg::jlsp_group_t secondLaneGroup, // group two lane frames
    output logic [7:0] firstLaneEnable, // group one lanes in use
    output logic [7:0] secondLaneEnable, // group two lanes in use
    output logic laneValid // lane frames hold a new frame
);

    // every check in this block runs on the frame clock and sleeps during reset
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------

    // sample above, overflow flag in the lsb
    function automatic logic [15:0] decWord(input logic [14:0] smp, input logic ovf);
        decWord = {smp, ovf};
    endfunction : decWord

    // two-octet lane frame; octet 0 sits in the top byte so it leaves first
    function automatic logic [31:0] twoOctet(input logic [15:0] word);
        twoOctet = {word, `JLSP_PAD16};
    endfunction : twoOctet

    // four 12-bit samples back to back: splitting the 48 bits into three
    // 16-bit chunks gives exactly the nibble-boundary split across lanes
    function automatic logic [47:0] packFour(
        input logic [11:0] s0,
        input logic [11:0] s1,
        input logic [11:0] s2,
        input logic [11:0] s3
    );
        packFour = {s0, s1, s2, s3};
    endfunction : packFour

    // ----------------------------------------------------------------
    // bypass packing groups
    // ----------------------------------------------------------------

    // single channel uses even/odd samples, dual channel uses halves
    wire logic [47:0] bypSingleALo;
    wire logic [47:0] bypSingleAHi;
    wire logic [47:0] bypSingleBLo;
    wire logic [47:0] bypSingleBHi;
    wire logic [47:0] bypDualALo;
    wire logic [47:0] bypDualAHi;
    wire logic [47:0] bypDualBLo;
    wire logic [47:0] bypDualBHi;

    assign bypSingleALo = packFour(bypassSample[0], bypassSample[2],
                                   bypassSample[4], bypassSample[6]);
    assign bypSingleAHi = packFour(bypassSample[8], bypassSample[10],
                                   bypassSample[12], bypassSample[14]);
    assign bypSingleBLo = packFour(bypassSample[1], bypassSample[3],
                                   bypassSample[5], bypassSample[7]);
    assign bypSingleBHi = packFour(bypassSample[9], bypassSample[11],
                                   bypassSample[13], bypassSample[15]);
    assign bypDualALo = packFour(bypassSample[0], bypassSample[1],
                                 bypassSample[2], bypassSample[3]);
    assign bypDualAHi = packFour(bypassSample[4], bypassSample[5],
                                 bypassSample[6], bypassSample[7]);
    assign bypDualBLo = packFour(bypassSample[8], bypassSample[9],
                                 bypassSample[10], bypassSample[11]);
    assign bypDualBHi = packFour(bypassSample[12], bypassSample[13],
                                 bypassSample[14], bypassSample[15]);

    // ----------------------------------------------------------------
    // lane mapping per mode
    // ----------------------------------------------------------------
    jlsp_pkg::jlsp_group_t laneA_d;
    jlsp_pkg::jlsp_group_t laneB_d;
    logic [7:0] enA_d;
    logic [7:0] enB_d;

    // unused lanes carry zeros so a stale mode never leaks old samples
    always_comb
    begin
        laneA_d = '0;
        laneB_d = '0;
        enA_d = `JLSP_MASK_NONE;
        enB_d = `JLSP_MASK_NONE;
        case (lanePackingMode)
            jlsp_pkg::D8_DUAL_L2:
            begin
                laneA_d[0] = {decWord(chanOneInphase[0], chanOneIOverflow[0]),
                              decWord(chanOneQuadrature[0], chanOneQOverflow[0])};
                laneB_d[0] = {decWord(chanTwoInphase[0], chanTwoIOverflow[0]),
                              decWord(chanTwoQuadrature[0], chanTwoQOverflow[0])};
                enA_d = `JLSP_MASK_1L;
                enB_d = `JLSP_MASK_1L;
            end
            jlsp_pkg::D8_DUAL_L4:
            begin
                laneA_d[0] = twoOctet(decWord(chanOneInphase[0], chanOneIOverflow[0]));
                laneA_d[1] = twoOctet(decWord(chanOneQuadrature[0], chanOneQOverflow[0]));
                laneB_d[0] = twoOctet(decWord(chanTwoInphase[0], chanTwoIOverflow[0]));
                laneB_d[1] = twoOctet(decWord(chanTwoQuadrature[0], chanTwoQOverflow[0]));
                enA_d = `JLSP_MASK_2L;
                enB_d = `JLSP_MASK_2L;
            end
            jlsp_pkg::D8_DUAL_L8:
            begin
                for (int k = 0; k < 2; k++)
                begin
                    laneA_d[k] = twoOctet(decWord(chanOneInphase[k], chanOneIOverflow[k]));
                    laneA_d[k + 2] = twoOctet(decWord(chanOneQuadrature[k],
                                                      chanOneQOverflow[k]));
                    laneB_d[k] = twoOctet(decWord(chanTwoInphase[k], chanTwoIOverflow[k]));
                    laneB_d[k + 2] = twoOctet(decWord(chanTwoQuadrature[k],
                                                      chanTwoQOverflow[k]));
                end
                enA_d = `JLSP_MASK_4L;
                enB_d = `JLSP_MASK_4L;
            end
            jlsp_pkg::D8_DUAL_L16:
            begin
                for (int k = 0; k < 4; k++)
                begin
                    laneA_d[k] = twoOctet(decWord(chanOneInphase[k], chanOneIOverflow[k]));
                    laneA_d[k + 4] = twoOctet(decWord(chanOneQuadrature[k],
                                                      chanOneQOverflow[k]));
                    laneB_d[k] = twoOctet(decWord(chanTwoInphase[k], chanTwoIOverflow[k]));
                    laneB_d[k + 4] = twoOctet(decWord(chanTwoQuadrature[k],
                                                      chanTwoQOverflow[k]));
                end
                enA_d = `JLSP_MASK_8L;
                enB_d = `JLSP_MASK_8L;
            end
            jlsp_pkg::BYP_SINGLE_L12:
            begin
                for (int k = 0; k < 3; k++)
                begin
                    laneA_d[k] = {bypSingleALo[47 - 16 * k -: 16], `JLSP_PAD16};
                    laneA_d[k + 3] = {bypSingleAHi[47 - 16 * k -: 16], `JLSP_PAD16};
                    laneB_d[k] = {bypSingleBLo[47 - 16 * k -: 16], `JLSP_PAD16};
                    laneB_d[k + 3] = {bypSingleBHi[47 - 16 * k -: 16], `JLSP_PAD16};
                end
                enA_d = `JLSP_MASK_6L;
                enB_d = `JLSP_MASK_6L;
            end
            jlsp_pkg::BYP_DUAL_L12:
            begin
                for (int k = 0; k < 3; k++)
                begin
                    laneA_d[k] = {bypDualALo[47 - 16 * k -: 16], `JLSP_PAD16};
                    laneA_d[k + 3] = {bypDualAHi[47 - 16 * k -: 16], `JLSP_PAD16};
                    laneB_d[k] = {bypDualBLo[47 - 16 * k -: 16], `JLSP_PAD16};
                    laneB_d[k + 3] = {bypDualBHi[47 - 16 * k -: 16], `JLSP_PAD16};
                end
                enA_d = `JLSP_MASK_6L;
                enB_d = `JLSP_MASK_6L;
            end
            jlsp_pkg::D4_SINGLE_L4, jlsp_pkg::D8_SINGLE_L4:
            begin
                // both decimations share one lane map at four lanes
                for (int k = 0; k < 2; k++)
                begin
                    laneA_d[k] = twoOctet(decWord(chanOneInphase[k],
                                                  inphaseOverflow[k]));
                    laneB_d[k] = twoOctet(decWord(chanOneQuadrature[k],
                                                  quadratureOverflow[k]));
                end
                enA_d = `JLSP_MASK_2L;
                enB_d = `JLSP_MASK_2L;
            end
            jlsp_pkg::D4_SINGLE_L8:
            begin
                for (int k = 0; k < 4; k++)
                begin
                    laneA_d[k] = twoOctet(decWord(chanOneInphase[k],
                                                  inphaseOverflow[k]));
                    laneB_d[k] = twoOctet(decWord(chanOneQuadrature[k],
                                                  quadratureOverflow[k]));
                end
                enA_d = `JLSP_MASK_4L;
                enB_d = `JLSP_MASK_4L;
            end
            jlsp_pkg::D8_SINGLE_L2:
            begin
                laneA_d[0] = twoOctet(decWord(chanOneInphase[0], inphaseOverflow[0]));
                laneB_d[0] = twoOctet(decWord(chanOneQuadrature[0],
                                              quadratureOverflow[0]));
                enA_d = `JLSP_MASK_1L;
                enB_d = `JLSP_MASK_1L;
            end
            default:
            begin
                laneA_d = '0;
                laneB_d = '0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // output registers
    // ----------------------------------------------------------------
    jlsp_pkg::jlsp_group_t laneA_q;
    jlsp_pkg::jlsp_group_t laneB_q;
    logic [7:0] enA_q;
    logic [7:0] enB_q;
    logic valid_q;

    // frames are captured only on a valid beat and held in between
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            laneA_q <= '0;
            laneB_q <= '0;
            enA_q <= `JLSP_MASK_NONE;
            enB_q <= `JLSP_MASK_NONE;
            valid_q <= 1'b0;
        end
        else
        begin
            laneA_q <= sampleValid ? laneA_d : laneA_q;
            laneB_q <= sampleValid ? laneB_d : laneB_q;
            enA_q <= sampleValid ? enA_d : enA_q;
            enB_q <= sampleValid ? enB_d : enB_q;
            valid_q <= sampleValid;
        end
    end

    assign firstLaneGroup = laneA_q;
    assign secondLaneGroup = laneB_q;
    assign firstLaneEnable = enA_q;
    assign secondLaneEnable = enB_q;
    assign laneValid = valid_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence beatIn(jlsp_pkg::jlsp_mode_t m);
        sampleValid && lanePackingMode == m;
    endsequence

    a_dual_two_lane: assert property (beatIn(jlsp_pkg::D8_DUAL_L2) |=>
        laneValid && firstLaneGroup[0][31:17] == $past(chanOneInphase[0])
        && firstLaneGroup[0][15:1] == $past(chanOneQuadrature[0])
        && secondLaneGroup[0][0] == $past(chanTwoQOverflow[0]))
        else $error("dual two-lane mapping wrong");

    a_dual_four_lane: assert property (beatIn(jlsp_pkg::D8_DUAL_L4) |=>
        secondLaneGroup[1][31:16] == {$past(chanTwoQuadrature[0]), $past(chanTwoQOverflow[0])}
        && firstLaneEnable == `JLSP_MASK_2L)
        else $error("dual four-lane mapping wrong");

    a_dual_eight_lane: assert property (beatIn(jlsp_pkg::D8_DUAL_L8) |=>
        firstLaneGroup[3][31:17] == $past(chanOneQuadrature[1])
        && secondLaneGroup[1][16] == $past(chanTwoIOverflow[1]))
        else $error("dual eight-lane mapping wrong");

    a_dual_sixteen_lane: assert property (beatIn(jlsp_pkg::D8_DUAL_L16) |=>
        firstLaneGroup[4][31:17] == $past(chanOneQuadrature[0])
        && secondLaneGroup[3][31:17] == $past(chanTwoInphase[3])
        && secondLaneEnable == `JLSP_MASK_8L)
        else $error("dual sixteen-lane mapping wrong");

    a_bypass_single_split: assert property (beatIn(jlsp_pkg::BYP_SINGLE_L12) |=>
        firstLaneGroup[1][31:24] == $past(bypassSample[2][7:0])
        && firstLaneGroup[2][31:28] == $past(bypassSample[4][3:0])
        && secondLaneGroup[5][27:16] == $past(bypassSample[15]))
        else $error("single bypass packing wrong");

    a_bypass_dual_split: assert property (beatIn(jlsp_pkg::BYP_DUAL_L12) |=>
        firstLaneGroup[3][31:20] == $past(bypassSample[4])
        && secondLaneGroup[0][19:16] == $past(bypassSample[9][11:8]))
        else $error("dual bypass packing wrong");

    a_single_dec4_lanes: assert property (beatIn(jlsp_pkg::D4_SINGLE_L8) |=>
        secondLaneGroup[3][31:16] == {$past(chanOneQuadrature[3]), $past(quadratureOverflow[3])}
        && firstLaneEnable == `JLSP_MASK_4L)
        else $error("single decimate-by-4 eight-lane mapping wrong");

    a_single_four_lane: assert property ((beatIn(jlsp_pkg::D4_SINGLE_L4)
        or beatIn(jlsp_pkg::D8_SINGLE_L4)) |=>
        firstLaneGroup[1][31:16] == {$past(chanOneInphase[1]), $past(inphaseOverflow[1])}
        && firstLaneGroup[2] == `JLSP_LANE_ZERO)
        else $error("single four-lane mapping wrong");

    a_single_two_lane: assert property (beatIn(jlsp_pkg::D8_SINGLE_L2) |=>
        secondLaneGroup[0] == {$past(chanOneQuadrature[0]), $past(quadratureOverflow[0]),
                               `JLSP_PAD16})
        else $error("single two-lane mapping wrong");

    a_frame_hold: assert property (laneValid ##1 !sampleValid [*2] |=>
        $stable(firstLaneGroup) && !laneValid)
        else $error("lane frame changed without a valid beat");

endmodule : jlsp_packer

//--- include/jlsp_params.svh
// constants for the lane sample packer: widths, paddings and lane masks
`ifndef JLSP_PARAMS_SVH
`define JLSP_PARAMS_SVH

// ----------------------------------------------------------------
// sample and lane widths
// ----------------------------------------------------------------
`define JLSP_DEC_W 15
`define JLSP_BYP_W 12
`define JLSP_WORD_W 16
`define JLSP_LANE_W 32
`define JLSP_GROUP_LANES 8
`define JLSP_DEC_SAMPLES 4
`define JLSP_BYP_SAMPLES 16
`define JLSP_PACK_W 48

// ----------------------------------------------------------------
// fill values and lane enable masks
// ----------------------------------------------------------------
`define JLSP_PAD16 16'h0000
`define JLSP_LANE_ZERO 32'h0000_0000
`define JLSP_MASK_NONE 8'h00
`define JLSP_MASK_1L 8'h01
`define JLSP_MASK_2L 8'h03
`define JLSP_MASK_4L 8'h0F
`define JLSP_MASK_6L 8'h3F
`define JLSP_MASK_8L 8'hFF

`endif

//--- include/jlsp_pkg.sv
// types for the lane sample packer
package jlsp_pkg;

    // ----------------------------------------------------------------
    // lane packing modes handled by this block
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        D8_DUAL_L2,
        D8_DUAL_L4,
        D8_DUAL_L8,
        D8_DUAL_L16,
        BYP_SINGLE_L12,
        BYP_DUAL_L12,
        D4_SINGLE_L4,
        D4_SINGLE_L8,
        D8_SINGLE_L2,
        D8_SINGLE_L4
    } jlsp_mode_t;

    typedef logic [3:0][14:0] jlsp_dec_vec_t;
    typedef logic [15:0][11:0] jlsp_byp_vec_t;
    typedef logic [7:0][31:0] jlsp_group_t;

endpackage : jlsp_pkg

//--- tb/jlsp_rx_model.sv
// receiver-side model of the lane sample packer: takes lane frames in arrival order
`timescale 1ns/10ps
module jlsp_rx_model (
    input wire logic core_clk, // frame clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic laneValid, // frame strobe from the packer
    input wire jlsp_pkg::jlsp_group_t firstLaneGroup, // group one lanes
    input wire jlsp_pkg::jlsp_group_t secondLaneGroup, // group two lanes
    output jlsp_pkg::jlsp_group_t rxFirst_q, // group one words as reassembled
    output jlsp_pkg::jlsp_group_t rxSecond_q // group two words as reassembled
);
    // ----------------------------------------------------------------
    // octet reassembly
    // ----------------------------------------------------------------
    // octets are taken one at a time in the order they leave the lane, so a
    // packer that swaps octets or nibbles shows up as a different word here
    function automatic logic [31:0] rebuild(input logic [31:0] lane);
        logic [31:0] r;
        r = 32'h0000_0000;
        for (int i = 0; i < 4; i++)
            r = {r[23:0], lane[31 - 8 * i -: 8]};
        return r;
    endfunction : rebuild

    // capture only on a frame strobe; stale frames must not be taken twice
    always_ff @(posedge core_clk)
        if (!rst_b)
        begin
            rxFirst_q <= '0;
            rxSecond_q <= '0;
        end
        else if (laneValid)
            for (int k = 0; k < 8; k++)
            begin
                rxFirst_q[k] <= rebuild(firstLaneGroup[k]);
                rxSecond_q[k] <= rebuild(secondLaneGroup[k]);
            end
endmodule : jlsp_rx_model

//--- tb/test_jlsp_packer.sv
// self-checking bench for the lane sample packer
`timescale 1ns/10ps
module test_jlsp_packer;
    logic core_clk, rst_b, sampleValid, laneValid;
    jlsp_pkg::jlsp_mode_t mode;
    jlsp_pkg::jlsp_dec_vec_t c1i, c1q, c2i, c2q;
    logic [3:0] c1io, c1qo, c2io, c2qo, io, qo;
    jlsp_pkg::jlsp_byp_vec_t byp;
    jlsp_pkg::jlsp_group_t grpA, grpB, rxA, rxB, expA, expB;
    logic [7:0] enA, enB, expEn;
    int n_errors = 0;
    int n_tests = 0;

    jlsp_packer DUT (.core_clk(core_clk), .rst_b(rst_b), .lanePackingMode(mode),
        .sampleValid(sampleValid), .chanOneInphase(c1i), .chanOneQuadrature(c1q),
        .chanTwoInphase(c2i), .chanTwoQuadrature(c2q), .chanOneIOverflow(c1io),
        .chanOneQOverflow(c1qo), .chanTwoIOverflow(c2io), .chanTwoQOverflow(c2qo),
        .inphaseOverflow(io), .quadratureOverflow(qo), .bypassSample(byp),
        .firstLaneGroup(grpA), .secondLaneGroup(grpB), .firstLaneEnable(enA),
        .secondLaneEnable(enB), .laneValid(laneValid));

    jlsp_rx_model u_rx (.core_clk(core_clk), .rst_b(rst_b), .laneValid(laneValid),
        .firstLaneGroup(grpA), .secondLaneGroup(grpB), .rxFirst_q(rxA), .rxSecond_q(rxB));

    // ----------------------------------------------------------------
    // clock, helpers and expected lane maps
    // ----------------------------------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // inputs move 2 ns after the edge so the packer never sees them mid-update
    task automatic tick();
        @(posedge core_clk);
        #2;
    endtask : tick

    task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [31:0] ln(input logic [14:0] s, input logic o);
        return {s, o, 16'h0000};
    endfunction : ln

    task automatic pk3(inout jlsp_pkg::jlsp_group_t g, input int l, input logic [47:0] p);
        g[l] = {p[47:32], 16'h0000};
        g[l + 1] = {p[31:16], 16'h0000};
        g[l + 2] = {p[15:0], 16'h0000};
    endtask : pk3

    // nd: lanes per I or Q in dual modes, ns: lanes per group in single modes
    task automatic build(input jlsp_pkg::jlsp_mode_t m);
        int nd, ns, lanes;
        expA = '0;
        expB = '0;
        nd = 0;
        ns = 0;
        lanes = 0;
        case (m)
            jlsp_pkg::D8_DUAL_L2:
            begin
                expA[0] = {c1i[0], c1io[0], c1q[0], c1qo[0]};
                expB[0] = {c2i[0], c2io[0], c2q[0], c2qo[0]};
                lanes = 1;
            end
            jlsp_pkg::D8_DUAL_L4: nd = 1;
            jlsp_pkg::D8_DUAL_L8: nd = 2;
            jlsp_pkg::D8_DUAL_L16: nd = 4;
            jlsp_pkg::D4_SINGLE_L4, jlsp_pkg::D8_SINGLE_L4: ns = 2;
            jlsp_pkg::D4_SINGLE_L8: ns = 4;
            jlsp_pkg::D8_SINGLE_L2: ns = 1;
            jlsp_pkg::BYP_SINGLE_L12, jlsp_pkg::BYP_DUAL_L12:
            begin
                lanes = 6;
                for (int g = 0; g < 2; g++)
                    if (m == jlsp_pkg::BYP_SINGLE_L12)
                    begin
                        pk3(expA, 3 * g, {byp[8*g], byp[8*g+2], byp[8*g+4], byp[8*g+6]});
                        pk3(expB, 3 * g, {byp[8*g+1], byp[8*g+3], byp[8*g+5], byp[8*g+7]});
                    end
                    else
                    begin
                        pk3(expA, 3 * g, {byp[4*g], byp[4*g+1], byp[4*g+2], byp[4*g+3]});
                        pk3(expB, 3 * g, {byp[8+4*g], byp[9+4*g], byp[10+4*g], byp[11+4*g]});
                    end
            end
            default: lanes = 0;
        endcase
        for (int k = 0; k < nd; k++)
        begin
            expA[k] = ln(c1i[k], c1io[k]);
            expA[k + nd] = ln(c1q[k], c1qo[k]);
            expB[k] = ln(c2i[k], c2io[k]);
            expB[k + nd] = ln(c2q[k], c2qo[k]);
        end
        for (int k = 0; k < ns; k++)
        begin
            expA[k] = ln(c1i[k], io[k]);
            expB[k] = ln(c1q[k], qo[k]);
        end
        lanes = lanes + 2 * nd + ns;
        expEn = 8'((1 << lanes) - 1);
    endtask : build

    // one frame in, pulse and enables one cycle later, receiver view after that
    task automatic frame(input jlsp_pkg::jlsp_mode_t m);
        mode = m;
        sampleValid = 1'b1;
        tick();
        sampleValid = 1'b0;
        build(m);
        check("laneValid", 256'(laneValid), 256'(1'b1));
        check("firstLaneEnable", 256'(enA), 256'(expEn));
        check("secondLaneEnable", 256'(enB), 256'(expEn));
        tick();
        check("laneValid low", 256'(laneValid), 256'(1'b0));
        check("rx first group", rxA, expA);
        check("rx second group", rxB, expB);
        check("held first group", grpA, expA);
    endtask : frame

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        check("first group in reset", grpA, '0);
        check("second group in reset", grpB, '0);
        check("flags in reset", {enA, enB, laneValid}, '0);
        rst_b = 1'b1;
        frame(jlsp_pkg::D8_DUAL_L16);
        rst_b = 1'b0;
        sampleValid = 1'b1;
        tick();
        check("group after reset", grpA, '0);
        check("valid after reset", {enA, laneValid}, '0);
        rst_b = 1'b1;
        sampleValid = 1'b0;
        $display("done reset");
    endtask : t_reset

    task automatic t_dual();
        for (int m = 0; m < 4; m++)
            frame(jlsp_pkg::jlsp_mode_t'(m));
        $display("done dual decimated");
    endtask : t_dual

    task automatic t_bypass();
        frame(jlsp_pkg::BYP_SINGLE_L12);
        frame(jlsp_pkg::BYP_DUAL_L12);
        $display("done bypass");
    endtask : t_bypass

    task automatic t_single();
        for (int m = 6; m < 10; m++)
            frame(jlsp_pkg::jlsp_mode_t'(m));
        $display("done single decimated");
    endtask : t_single

    // mode changes between two frames that arrive on consecutive edges
    task automatic t_back_to_back();
        mode = jlsp_pkg::D8_DUAL_L2;
        sampleValid = 1'b1;
        tick();
        mode = jlsp_pkg::BYP_DUAL_L12;
        tick();
        sampleValid = 1'b0;
        build(jlsp_pkg::D8_DUAL_L2);
        check("rx first frame", rxA, expA);
        build(jlsp_pkg::BYP_DUAL_L12);
        check("second frame", grpB, expB);
        check("laneValid held", 256'(laneValid), 256'(1'b1));
        tick();
        check("rx second frame", rxB, expB);
        // idle edges after the pulse: lanes must hold and the strobe stay low
        repeat (3) tick();
        check("idle held frame", grpB, expB);
        check("idle laneValid", 256'(laneValid), 256'(1'b0));
        $display("done back to back");
    endtask : t_back_to_back

    task automatic t_bad_mode();
        frame(jlsp_pkg::jlsp_mode_t'(4'hC));
        $display("done unsupported mode");
    endtask : t_bad_mode

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    initial
    begin
        #(25 * 2000);
        n_errors++;
        $display("ERROR watchdog expected finish seen hang");
        print_verdict();
    end

    initial
    begin
        rst_b = 1'b0;
        sampleValid = 1'b0;
        mode = jlsp_pkg::D8_DUAL_L2;
        for (int k = 0; k < 4; k++)
        begin
            c1i[k] = 15'h1A50 + 15'(k * 15'h0111);
            c1q[k] = 15'h2B60 + 15'(k * 15'h0111);
            c2i[k] = 15'h3C70 + 15'(k * 15'h0111);
            c2q[k] = 15'h4D80 + 15'(k * 15'h0111);
        end
        {c1io, c1qo, c2io, c2qo, io, qo} = 24'h5A3C69;
        for (int k = 0; k < 16; k++)
            byp[k] = 12'h5A3 ^ 12'(k * 12'h111);
        repeat (12) @(posedge core_clk);
        #2;
        t_reset();
        t_dual();
        t_bypass();
        t_single();
        t_back_to_back();
        t_bad_mode();
        print_verdict();
    end
endmodule : test_jlsp_packer
